// ==== rtl/vbc_pkg.sv ====
package vbc_pkg;
  // apb register byte offsets
  localparam logic [7:0] VBC_CTRL_OFS = 8'h00;
  localparam logic [7:0] VBC_HCAP_OFS = 8'h04;
  localparam logic [7:0] VBC_VERT_OFS = 8'h08;
  localparam logic [7:0] VBC_STAT_OFS = 8'h0C;
  // control field positions
  localparam int VBC_PAL_BIT = 0;
  localparam int VBC_ELINE_BIT = 1;
  localparam int VBC_OLINE_BIT = 2;
  localparam int VBC_ECAP_BIT = 3;
  localparam int VBC_OCAP_BIT = 4;
  localparam int VBC_ERAW_BIT = 5;
  localparam int VBC_ORAW_BIT = 6;
  localparam int VBC_EXT_BIT = 7;
  localparam int VBC_CNT_LO_POS = 16;
  localparam int VBC_CNT_HI_BIT = 24;
  // reset values
  localparam logic [7:0] VBC_CTRL_RST = 8'h00;
  localparam logic [9:0] VBC_HSTART_RST = 10'h000;
  localparam logic [8:0] VBC_COUNT_RST = 9'h000;
  localparam logic [9:0] VBC_VERTICAL_START_DELAY_RST = 10'h016;
  // frame geometry in lines
  localparam logic [9:0] VBC_NTSC_LINES = 10'd525;
  localparam logic [9:0] VBC_PAL_LINES = 10'd625;
  localparam logic [9:0] VBC_NTSC_F2 = 10'd264;
  localparam logic [9:0] VBC_PAL_F2 = 10'd314;
  localparam logic [9:0] VBC_SYNC1_END = 10'd9;
  localparam logic [9:0] VBC_BLANK1_END = 10'd20;
  localparam logic [9:0] VBC_PIC1_END = 10'd263;
  localparam logic [9:0] VBC_SYNC2_END = 10'd272;
  localparam logic [9:0] VBC_BLANK2_END = 10'd283;
  localparam logic [9:0] VBC_EXT_LINES = 10'd10;
  // frame mode block sizes
  localparam logic [7:0] VBC_BLOCK_LAST = 8'hFF;
  localparam logic [9:0] VBC_BLK_NTSC = 10'd434;
  localparam logic [9:0] VBC_BLK_PAL = 10'd650;
  localparam logic [9:0] VBC_BLK_NTSC_EXT = 10'd450;
  localparam logic [9:0] VBC_BLK_PAL_EXT = 10'd674;
  typedef enum logic [1:0] {
    VBC_RG_SYNC = 2'b00,
    VBC_RG_BLANK = 2'b01,
    VBC_RG_PIC = 2'b10
  } vbc_region_t;
endpackage

// ==== rtl/vbc_pack_if.sv ====
`timescale 1ns/1ps
interface vbc_pack_if;
  logic clear;
  logic smp_vld;
  logic [7:0] smp;
  logic dw_vld;
  logic [31:0] dw;
  modport src (output clear, output smp_vld, output smp, input dw_vld,
    input dw);
  modport pk (input clear, input smp_vld, input smp, output dw_vld,
    output dw);
endinterface

// ==== rtl/vbc_packer.sv ====
`timescale 1ns/1ps
module vbc_packer (
  input wire logic pclk,
  input wire logic presetn,
  vbc_pack_if.pk p
);
  logic [1:0] idx_ff;
  logic [23:0] hold_ff;
  logic dw_vld_ff;
  logic [31:0] dw_ff;
  wire last_byte = p.smp_vld && (idx_ff == 2'h3);

  // first sample lands in byte lane 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_ff <= 2'h0;
      hold_ff <= 24'h000000;
      dw_vld_ff <= 1'b0;
      dw_ff <= 32'h00000000;
    end else begin
      dw_vld_ff <= last_byte && !p.clear;
      if (last_byte) begin
        dw_ff <= {p.smp, hold_ff};
      end
      if (p.clear) begin
        idx_ff <= 2'h0;
      end else if (p.smp_vld) begin
        idx_ff <= idx_ff + 2'h1;
        hold_ff <= {p.smp, hold_ff[23:8]};
      end
    end
  end

  assign p.dw_vld = dw_vld_ff;
  assign p.dw = dw_ff;

  chk_four_bytes: assert property (@(posedge pclk) disable iff (!presetn)
    (p.smp_vld && !p.clear && idx_ff == 2'h3) |=> dw_vld_ff)
    else $error("packer missed a full dword");
endmodule

// ==== rtl/vbc_top.sv ====
// Behaviour
// - frame is 525 lines ntsc, 625 pal
// - ntsc picture lines 21-263 and 283-525
// - ntsc sync lines 1-9 and 264-272
// - ntsc blanking data lines 10-20, 273-282
// - line and frame capture share a field
// - line capture starts pixels after line strobe
// - four samples per dword, two per pixel
// - nine bit dword count from two fields
// - per field line capture enables
// - samples stored one byte after another
// - line capture stops after programmed dwords
// - line capture from field start to window
// - configuration changes only at frame boundary
// - larger vertical delay widens line region
// - frame capture keeps blanking and sync samples
// - frame capture from window, fixed blocks
// - 256 dword blocks, 434 ntsc, 650 pal
// - extended frame: 10 lines early, 450/674
// - frame capture needs enable and raw format
// - frame stream never realigned to lines
// - captured data leaves through normal fifo
// - vertical delay counts half lines
`timescale 1ns/1ps
module vbc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic line_start_strobe_n,
  input wire logic field_start_strobe_n,
  input wire logic field_odd,
  input wire logic sample_vld,
  input wire logic [7:0] sample,
  output logic [31:0] fifo_data,
  output logic fifo_valid,
  output logic fifo_raw,
  output logic fifo_block_end,
  output vbc_pkg::vbc_region_t region
);
  import vbc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // apb slave
  logic [7:0] ctrl_ff;
  logic [9:0] hstart_ff;
  logic [8:0] count_ff;
  logic [9:0] vertical_start_delay_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic [31:0] status_w;
  logic [31:0] rd_mux;

  wire acc = psel && penable && !pready_ff;
  wire wr_en = psel && penable && pready_ff && pwrite;
  wire hit_ctrl = paddr == VBC_CTRL_OFS;
  wire hit_hcap = paddr == VBC_HCAP_OFS;
  wire hit_vert = paddr == VBC_VERT_OFS;
  wire hit_stat = paddr == VBC_STAT_OFS;
  wire hit_any = hit_ctrl || hit_hcap || hit_vert || hit_stat;
  wire bad_wr = pwrite && hit_stat;

  assign rd_mux = hit_ctrl ? {24'h000000, ctrl_ff} :
    hit_hcap ? {7'h00, count_ff, 6'h00, hstart_ff} :
    hit_vert ? {22'h000000, vertical_start_delay_ff} :
    hit_stat ? status_w : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      pready_ff <= acc;
      pslverr_ff <= acc && (!hit_any || bad_wr);
      prdata_ff <= (acc && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= VBC_CTRL_RST;
      hstart_ff <= VBC_HSTART_RST;
      count_ff <= VBC_COUNT_RST;
      vertical_start_delay_ff <= VBC_VERTICAL_START_DELAY_RST;
    end else if (wr_en) begin
      if (hit_ctrl) begin
        ctrl_ff <= pwdata[7:0];
      end
      if (hit_hcap) begin
        hstart_ff <= pwdata[9:0];
        count_ff <= {pwdata[VBC_CNT_HI_BIT],
          pwdata[VBC_CNT_LO_POS +: 8]};
      end
      if (hit_vert) begin
        vertical_start_delay_ff <= pwdata[9:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // strobe edges and frame shadow of the configuration
  logic ls_q_ff;
  logic fs_q_ff;
  logic [7:0] sh_ctrl_ff;
  logic [9:0] sh_hstart_ff;
  logic [8:0] sh_count_ff;
  logic [9:0] sh_vertical_start_delay_ff;

  wire line_edge = line_start_strobe_n && !ls_q_ff;
  wire field_edge = field_start_strobe_n && !fs_q_ff;
  wire frame_edge = field_edge && field_odd;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ls_q_ff <= 1'b1;
      fs_q_ff <= 1'b1;
      sh_ctrl_ff <= VBC_CTRL_RST;
      sh_hstart_ff <= VBC_HSTART_RST;
      sh_count_ff <= VBC_COUNT_RST;
      sh_vertical_start_delay_ff <= VBC_VERTICAL_START_DELAY_RST;
    end else begin
      ls_q_ff <= line_start_strobe_n;
      fs_q_ff <= field_start_strobe_n;
      if (frame_edge) begin
        sh_ctrl_ff <= ctrl_ff;
        sh_hstart_ff <= hstart_ff;
        sh_count_ff <= count_ff;
        sh_vertical_start_delay_ff <= vertical_start_delay_ff;
      end
    end
  end

  wire pal = sh_ctrl_ff[VBC_PAL_BIT];
  wire ext = sh_ctrl_ff[VBC_EXT_BIT];

  ////////////////////////////////////////////////////////////////////////
  // line counters and regions
  logic [9:0] line_cnt_ff;
  logic [9:0] frame_line_ff;
  logic odd_ff;
  vbc_region_t region_ff;
  vbc_region_t nxt_region;

  wire [9:0] frame_len = pal ? VBC_PAL_LINES : VBC_NTSC_LINES;
  wire [9:0] f2_first = pal ? VBC_PAL_F2 : VBC_NTSC_F2;
  wire [9:0] win_line = {1'b0, sh_vertical_start_delay_ff[9:1]};
  wire [9:0] ext_line = (win_line > VBC_EXT_LINES) ?
    win_line - VBC_EXT_LINES : 10'd1;
  wire [9:0] raw_line = ext ? ext_line : win_line;
  wire [9:0] nxt_line = line_cnt_ff + 10'd1;
  wire [9:0] nxt_fline = (frame_line_ff == frame_len) ? 10'd1 :
    frame_line_ff + 10'd1;

  always_comb begin
    if (frame_line_ff <= VBC_SYNC1_END) begin
      nxt_region = VBC_RG_SYNC;
    end else if (frame_line_ff <= VBC_BLANK1_END) begin
      nxt_region = VBC_RG_BLANK;
    end else if (frame_line_ff <= VBC_PIC1_END) begin
      nxt_region = VBC_RG_PIC;
    end else if (frame_line_ff <= VBC_SYNC2_END) begin
      nxt_region = VBC_RG_SYNC;
    end else if (frame_line_ff < VBC_BLANK2_END) begin
      nxt_region = VBC_RG_BLANK;
    end else begin
      nxt_region = VBC_RG_PIC;
    end
    if (pal) begin
      nxt_region = (line_cnt_ff < win_line) ? VBC_RG_BLANK : VBC_RG_PIC;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_cnt_ff <= 10'd0;
      frame_line_ff <= 10'd1;
      odd_ff <= 1'b1;
      region_ff <= VBC_RG_SYNC;
    end else begin
      region_ff <= nxt_region;
      if (field_edge) begin
        line_cnt_ff <= 10'd0;
        odd_ff <= field_odd;
        frame_line_ff <= field_odd ? 10'd1 : f2_first;
      end else if (line_edge) begin
        line_cnt_ff <= nxt_line;
        frame_line_ff <= nxt_fline;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // line mode window
  logic lm_on_ff;
  logic half_ff;
  logic [9:0] pix_ff;
  logic [10:0] smp_cnt_ff;

  wire line_en = odd_ff ? sh_ctrl_ff[VBC_OLINE_BIT] :
    sh_ctrl_ff[VBC_ELINE_BIT];
  wire in_line_rg = (nxt_line >= 10'd1) && (nxt_line < win_line);
  wire lm_arm = line_edge && line_en && in_line_rg;
  wire [10:0] smp_lim = {sh_count_ff, 2'b00};
  wire lm_take = lm_on_ff && sample_vld && (pix_ff >= sh_hstart_ff) &&
    (smp_cnt_ff < smp_lim);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lm_on_ff <= 1'b0;
      half_ff <= 1'b0;
      pix_ff <= 10'd0;
      smp_cnt_ff <= 11'd0;
    end else if (field_edge || line_edge) begin
      lm_on_ff <= lm_arm && !field_edge;
      half_ff <= 1'b0;
      pix_ff <= 10'd0;
      smp_cnt_ff <= 11'd0;
    end else if (lm_on_ff && sample_vld) begin
      half_ff <= !half_ff;
      if (half_ff && pix_ff != 10'h3FF) begin
        pix_ff <= pix_ff + 10'd1;
      end
      if (lm_take) begin
        smp_cnt_ff <= smp_cnt_ff + 11'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame mode packets
  logic fm_on_ff;
  logic [7:0] blk_dw_ff;
  logic [9:0] blk_cnt_ff;

  wire raw_en = odd_ff ?
    (sh_ctrl_ff[VBC_OCAP_BIT] && sh_ctrl_ff[VBC_ORAW_BIT]) :
    (sh_ctrl_ff[VBC_ECAP_BIT] && sh_ctrl_ff[VBC_ERAW_BIT]);
  wire [9:0] blk_target = pal ? (ext ? VBC_BLK_PAL_EXT : VBC_BLK_PAL) :
    (ext ? VBC_BLK_NTSC_EXT : VBC_BLK_NTSC);
  wire fm_start = line_edge && raw_en && (nxt_line == raw_line);
  wire fm_take = fm_on_ff && sample_vld;

  vbc_pack_if pk_if ();

  wire fm_dw = fm_on_ff && pk_if.dw_vld;
  wire blk_done = fm_dw && (blk_dw_ff == VBC_BLOCK_LAST);
  wire last_blk = blk_done && (blk_cnt_ff + 10'd1 == blk_target);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fm_on_ff <= 1'b0;
      blk_dw_ff <= 8'h00;
      blk_cnt_ff <= 10'd0;
    end else if (field_edge) begin
      fm_on_ff <= 1'b0;
      blk_dw_ff <= 8'h00;
      blk_cnt_ff <= 10'd0;
    end else begin
      if (fm_start && !fm_on_ff) begin
        fm_on_ff <= 1'b1;
      end else if (last_blk) begin
        fm_on_ff <= 1'b0;
      end
      if (fm_dw) begin
        blk_dw_ff <= blk_dw_ff + 8'h01;
      end
      if (blk_done) begin
        blk_cnt_ff <= blk_cnt_ff + 10'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sample packing and fifo output
  // frame mode holds priority; line mode yields where they overlap
  assign pk_if.smp_vld = fm_on_ff ? fm_take : lm_take;
  assign pk_if.smp = sample;
  assign pk_if.clear = field_edge || (line_edge && !fm_on_ff);

  vbc_packer u_packer (
    .pclk(pclk),
    .presetn(presetn),
    .p(pk_if.pk)
  );

  logic [31:0] fifo_data_ff;
  logic fifo_valid_ff;
  logic fifo_raw_ff;
  logic blk_end_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_data_ff <= 32'h00000000;
      fifo_valid_ff <= 1'b0;
      fifo_raw_ff <= 1'b0;
      blk_end_ff <= 1'b0;
    end else begin
      fifo_valid_ff <= pk_if.dw_vld;
      fifo_raw_ff <= fm_on_ff;
      blk_end_ff <= blk_done;
      if (pk_if.dw_vld) begin
        fifo_data_ff <= pk_if.dw;
      end
    end
  end

  assign status_w = {blk_cnt_ff, 2'b00, line_cnt_ff, 5'h00,
    region_ff, odd_ff, fm_on_ff, lm_on_ff};
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign fifo_data = fifo_data_ff;
  assign fifo_valid = fifo_valid_ff;
  assign fifo_raw = fifo_raw_ff;
  assign fifo_block_end = blk_end_ff;
  assign region = region_ff;

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_line_count_cap: assert property (@(posedge pclk)
    disable iff (!presetn) smp_cnt_ff <= smp_lim || smp_cnt_ff == 11'd0)
    else $error("line capture exceeded dword count");
  chk_line_field_en: assert property (@(posedge pclk)
    disable iff (!presetn) lm_take |-> line_en)
    else $error("line capture in disabled field");
  chk_line_hstart: assert property (@(posedge pclk)
    disable iff (!presetn) lm_take |-> pix_ff >= sh_hstart_ff)
    else $error("line capture before horizontal start");
  chk_line_rearm: assert property (@(posedge pclk)
    disable iff (!presetn) lm_arm && !field_edge |=> lm_on_ff &&
    smp_cnt_ff == 11'd0 && pix_ff == 10'd0)
    else $error("line window not rearmed");
  chk_raw_enable: assert property (@(posedge pclk)
    disable iff (!presetn) $rose(fm_on_ff) |-> $past(raw_en))
    else $error("frame capture without raw enable");
  chk_raw_stop: assert property (@(posedge pclk)
    disable iff (!presetn) last_blk && !field_edge |=> !fm_on_ff &&
    blk_cnt_ff == blk_target)
    else $error("frame capture block count wrong");
  chk_cfg_frame: assert property (@(posedge pclk)
    disable iff (!presetn) !$past(frame_edge) |-> $stable(sh_ctrl_ff))
    else $error("config changed inside frame");
  chk_fifo_follow: assert property (@(posedge pclk)
    disable iff (!presetn) pk_if.dw_vld |=> fifo_valid_ff &&
    fifo_data_ff == $past(pk_if.dw))
    else $error("dword not forwarded to fifo");
  chk_frame_wrap: assert property (@(posedge pclk)
    disable iff (!presetn) frame_line_ff <= frame_len)
    else $error("frame line beyond frame length");
  chk_apb_answer: assert property (@(posedge pclk)
    disable iff (!presetn) acc |=> pready_ff ##1 !pready_ff)
    else $error("apb answer not one cycle");
endmodule

// ==== dv/vbc_video_src.sv ====
`timescale 1ns/1ps
module vbc_video_src (
  input wire logic pclk,
  input wire logic go,
  input wire logic odd,
  input wire logic [9:0] lines,
  input wire logic [9:0] spl,
  input wire logic [7:0] salt,
  output logic busy,
  output logic line_start_strobe_n,
  output logic field_start_strobe_n,
  output logic field_odd,
  output logic sample_vld,
  output logic [7:0] sample
);
  int n;
  function automatic logic [7:0] smp(int i);
    return 8'(i) ^ 8'(i >> 8) ^ salt;
  endfunction
  initial begin
    busy = 1'b0;
    line_start_strobe_n = 1'b1;
    field_start_strobe_n = 1'b1;
    field_odd = 1'b0;
    sample_vld = 1'b0;
    sample = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one field: field strobe, then lines of samples
  always begin
    @(posedge pclk);
    if (go) begin
      busy <= 1'b1;
      field_odd <= odd;
      field_start_strobe_n <= 1'b0;
      @(posedge pclk);
      field_start_strobe_n <= 1'b1;
      n = 0;
      for (int l = 0; l < lines; l++) begin
        @(posedge pclk);
        line_start_strobe_n <= 1'b0;
        @(posedge pclk);
        line_start_strobe_n <= 1'b1;
        for (int k = 0; k < spl; k++) begin
          @(posedge pclk);
          sample_vld <= 1'b1;
          sample <= smp(n);
          n++;
          @(posedge pclk);
          sample_vld <= 1'b0;
          // stale byte never left on the bus
          sample <= ~smp(n - 1);
        end
      end
      @(posedge pclk);
      busy <= 1'b0;
    end
  end
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/1ps
module tb;
  import vbc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, sample, salt;
  logic [31:0] pwdata, prdata, fifo_data, rd;
  logic line_start_strobe_n, field_start_strobe_n, field_odd, sample_vld;
  logic fifo_valid, fifo_raw, fifo_block_end, go, odd, busy;
  logic [9:0] lines, spl;
  vbc_region_t region;
  int n_errors, n_tests, n_blk, cyc, h, c, s;
  logic [31:0] got_q[$], exp_q[$];
  logic raw_q[$];

  vbc_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .line_start_strobe_n, .field_start_strobe_n,
    .field_odd, .sample_vld, .sample, .fifo_data, .fifo_valid, .fifo_raw,
    .fifo_block_end, .region);
  vbc_video_src src (.pclk, .go, .odd, .lines, .spl, .salt, .busy,
    .line_start_strobe_n, .field_start_strobe_n, .field_odd, .sample_vld,
    .sample);

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // monitor and timeout
  always @(posedge pclk) begin
    cyc++;
    if (fifo_valid === 1'b1) begin
      got_q.push_back(fifo_data);
      raw_q.push_back(fifo_raw);
    end
    if (fifo_block_end === 1'b1) n_blk++;
    if (cyc == 60000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic tally_and_finish;
    if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [7:0] smp(int i);
    return 8'(i) ^ 8'(i >> 8) ^ salt;
  endfunction
  task automatic add_dw(input int n0, input int cnt);
    for (int j = 0; j < cnt; j++) begin
      exp_q.push_back({smp(n0 + 4 * j + 3), smp(n0 + 4 * j + 2),
        smp(n0 + 4 * j + 1), smp(n0 + 4 * j)});
    end
  endtask
  task automatic field(input logic o, input int nl, input int ns);
    odd <= o;
    lines <= 10'(nl);
    spl <= 10'(ns);
    go <= 1'b1;
    repeat (2) @(posedge pclk);
    go <= 1'b0;
    while (busy === 1'b1) @(posedge pclk);
    repeat (4) @(posedge pclk);
  endtask
  task automatic cmp_q(input logic raw);
    check(got_q.size(), exp_q.size());
    foreach (exp_q[i]) begin
      if (i < got_q.size()) begin
        check(got_q[i], exp_q[i]);
        check(raw_q[i], raw);
      end
    end
    got_q.delete();
    raw_q.delete();
    exp_q.delete();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    n_errors = 0;
    n_tests = 0;
    n_blk = 0;
    cyc = 0;
    {psel, penable, pwrite, presetn, go, odd} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    lines = 10'h000;
    spl = 10'h000;
    salt = 8'($urandom(67066));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, VBC_CTRL_OFS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, VBC_VERT_OFS, 32'h0);
    check(rd, {22'h0, VBC_VERTICAL_START_DELAY_RST});
    apb(1'b1, VBC_HCAP_OFS, 32'h0155_00AB);
    apb(1'b0, VBC_HCAP_OFS, 32'h0);
    check(rd, 32'h0155_00AB);
    apb(1'b0, 8'h10, 32'h0);
    check({rd[30:0], err}, 32'h1);
    apb(1'b1, VBC_STAT_OFS, 32'hFFFF_FFFF);
    check(err, 1'b1);
    // line mode: window ends at line 11 with the reset delay
    h = $urandom_range(0, 40);
    c = $urandom_range(1, 8);
    s = 2 * h + 4 * c + 8;
    apb(1'b1, VBC_HCAP_OFS, {7'h0, 9'(c), 6'h0, 10'(h)});
    apb(1'b1, VBC_CTRL_OFS, 32'h6);
    for (int f = 0; f < 4; f++) begin
      if (f != 2) begin
        for (int l = 1; l <= 10; l++) add_dw((l - 1) * s + 2 * h, c);
      end
      field(~f[0], 12, s);
      cmp_q(1'b0);
      if (f == 0) begin
        check(32'(region), 32'(VBC_RG_BLANK));
        apb(1'b1, VBC_CTRL_OFS, 32'h2);
      end
    end
    // frame mode, plain then extended start
    for (int e = 0; e < 2; e++) begin
      apb(1'b1, VBC_CTRL_OFS, e ? 32'hD0 : 32'h50);
      apb(1'b1, VBC_VERT_OFS, e ? 32'h2 : 32'h4);
      n_blk = 0;
      add_dw((1 - e) * 300, (4 + e) * 75);
      field(1'b1, 5, 300);
      cmp_q(1'b1);
      check(n_blk, 1);
      check(32'(region), 32'(VBC_RG_SYNC));
    end
    // status: one block, line 5, sync, odd, frame mode still on
    apb(1'b0, VBC_STAT_OFS, 32'h0);
    check(rd, 32'h0040_1406);
    tally_and_finish();
  end
endmodule
